/* File: logic/rpd_pkg.sv */
// constants and carrier types for the receive pattern monitor
//
// Overview of operation
// (R1) pattern output shows alarm unless pseudo-random mode
// (R2) alarm high: under three zeros per 2048 bits
// (R3) alarm low: over three zeros per 2048 bits
// (R4) alarm watches line data, ignoring any loopback
// (R5) pseudo-random mode: output high until pattern lock
// (R6) sync by 3, loss by 4 errors/128 bits
// (R7) after lock each bit error pulses output high
// (R8) edge select high: data valid on falling edge
// (R9) edge select low: data valid on rising edge
// (R10) edge select high: serial data valid rising shift
// (R11) edge select low: serial data valid falling shift
// (R12) far side drives aux pin high to enable
// (R13) monitor on receive clock, alarm window restarts
`default_nettype none

package rpd_pkg;

    // ******************************************
    // alarm window
    // ******************************************
    localparam logic [10:0] AIS_WIN_LAST   = 11'h7FF; // bit 2048 of span
    localparam logic [2:0]  AIS_ZERO_LIMIT = 3'h3;    // zero threshold
    localparam logic [2:0]  AIS_ZERO_SAT   = 3'h4;    // zero count ceiling

    // ******************************************
    // pseudo-random checker
    // ******************************************
    localparam logic [6:0]  QRSS_SPAN_LAST = 7'h7F;   // bit 128 of span
    localparam logic [2:0]  QRSS_ACQ_ERRS  = 3'h3;    // lock below this
    localparam logic [2:0]  QRSS_LOSS_ERRS = 3'h4;    // unlock at this
    localparam logic [2:0]  QRSS_ERR_SAT   = 3'h4;    // error count ceiling
    localparam int          PRBS_TAP_A     = 16;      // x^17 tap index
    localparam int          PRBS_TAP_B     = 19;      // x^20 tap index

    // ******************************************
    // reset values and pin indices
    // ******************************************
    localparam logic        RST_ALARM      = 1'b0;    // alarm clear
    localparam logic        RST_PATTERN    = 1'b0;    // output low
    localparam int          PIN_EDGE       = 0;       // edge select
    localparam int          PIN_AUX_SEL    = 1;       // function select
    localparam int          PIN_AUX_PIN    = 2;       // function pin
    localparam int          PIN_SCLK       = 3;       // serial shift clock
    localparam int          PIN_COUNT      = 4;       // synchronised pins

    // one received bit as positive and negative marks
    typedef struct packed {
        logic pos;
        logic neg;
    } rpd_rx_bits_t;

    // pseudo-random lock state
    typedef enum {
        RPD_HUNT,
        RPD_LOCK
    } rpd_qrss_state_t;

endpackage : rpd_pkg

`default_nettype wire

/* File: logic/rpd_monitor.sv */
// receive pattern monitor with edge-selected data and serial outputs
`default_nettype none

module rpd_monitor
(
    input  wire logic                  mclk,             // system clock
    input  wire logic                  rst,              // sync reset
    input  wire logic                  rxBitStrobe,      // one per bit
    input  wire rpd_pkg::rpd_rx_bits_t rxLineBits,       // recovered bit
    input  wire logic                  edgeSelect,       // pin
    input  wire logic                  auxFunctionSelect,// pin
    input  wire logic                  auxFunctionPin,   // pin
    input  wire logic                  serialShiftClk,   // pin
    input  wire logic                  serialNextBit,    // bit to present
    output logic                       rxPositiveData,   // receive data
    output logic                       rxNegativeData,   // receive data
    output logic                       rxClkOut,         // receive clock
    output logic                       serialReadData,   // serial out
    output logic                       patternDetectOut  // detect output
);

    // ******************************************
    // helpers
    // ******************************************
    // a mark on either rail counts as a one
    function automatic logic rpd_is_mark(input rpd_pkg::rpd_rx_bits_t b);
        rpd_is_mark = b.pos | b.neg;
    endfunction : rpd_is_mark

    // ******************************************
    // pin synchronisers
    // ******************************************
    logic [rpd_pkg::PIN_COUNT-1:0] pinRaw;   // raw pins
    logic [rpd_pkg::PIN_COUNT-1:0] syncA;    // first stage only
    logic [rpd_pkg::PIN_COUNT-1:0] syncB;    // usable level
    logic                          edgeSel;  // synced edge select
    logic                          qrssOn;   // pseudo-random active
    logic                          sclk;     // synced shift clock

    assign pinRaw = {serialShiftClk, auxFunctionPin,
                     auxFunctionSelect, edgeSelect};

    // two flops per pin, first stage read only by second
    genvar gi;
    generate
        for (gi = 0; gi < rpd_pkg::PIN_COUNT; gi++)
        begin : g_sync
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    syncA[gi] <= 1'b0;
                    syncB[gi] <= 1'b0;
                end
                else
                begin
                    syncA[gi] <= pinRaw[gi];
                    syncB[gi] <= syncA[gi];
                end
            end
        end
    endgenerate

    assign edgeSel = syncB[rpd_pkg::PIN_EDGE];
    // detector runs only with select and far-side pin high
    assign qrssOn  = syncB[rpd_pkg::PIN_AUX_SEL] &
                     syncB[rpd_pkg::PIN_AUX_PIN];  // [R12]
    assign sclk    = syncB[rpd_pkg::PIN_SCLK];

    // ******************************************
    // state
    // ******************************************
    logic [10:0]              winCount, next_winCount;   // window bit
    logic [2:0]               zeroCount, next_zeroCount; // zeros seen
    logic                     aisAlarm, next_aisAlarm;   // alarm level
    logic [2:0]               zeroTally;                 // incl. this bit
    logic [19:0]              refShift, next_refShift;   // reference
    logic [6:0]               spanCount, next_spanCount; // span bit
    logic [2:0]               errCount, next_errCount;   // span errors
    logic [2:0]               errTally;                  // incl. this bit
    rpd_pkg::rpd_qrss_state_t qState, next_qState;       // lock state
    logic                     rxBit;                     // bit as 0/1
    logic                     bitErr;                    // mismatch
    logic                     next_pattern;              // output next
    rpd_pkg::rpd_rx_bits_t    rxHold, next_rxHold;       // data out
    logic                     next_rxClk;                // clock next
    logic                     sclkPrev;                  // edge detect
    logic                     next_serial;               // serial next

    assign rxBit     = rpd_is_mark(rxLineBits);
    assign zeroTally = (!rxBit && zeroCount != rpd_pkg::AIS_ZERO_SAT)
                     ? zeroCount + 3'h1 : zeroCount;
    assign bitErr    = rxBitStrobe & qrssOn &
                       (rxBit != (refShift[rpd_pkg::PRBS_TAP_A] ^
                                  refShift[rpd_pkg::PRBS_TAP_B]));
    assign errTally  = (bitErr && errCount != rpd_pkg::QRSS_ERR_SAT)
                     ? errCount + 3'h1 : errCount;

    // ******************************************
    // alarm window
    // ******************************************
    // counts zeros straight off the line, no loopback path here
    always_comb
    begin
        next_winCount  = winCount;
        next_zeroCount = zeroCount;
        next_aisAlarm  = aisAlarm;
        if (rxBitStrobe)
        begin
            next_winCount  = winCount + 11'h001;
            next_zeroCount = zeroTally;            // [R4]
            if (winCount == rpd_pkg::AIS_WIN_LAST)
            begin
                // window ends: judge and restart
                next_winCount  = 11'h000;          // [R13]
                next_zeroCount = 3'h0;             // [R13]
                if (zeroTally < rpd_pkg::AIS_ZERO_LIMIT)
                    next_aisAlarm = 1'b1;          // [R2]
                else if (zeroTally > rpd_pkg::AIS_ZERO_LIMIT)
                    next_aisAlarm = 1'b0;          // [R3]
            end
        end
    end

    // ******************************************
    // pseudo-random checker
    // ******************************************
    // self-synchronising reference fed from received bits
    always_comb
    begin
        next_refShift  = refShift;
        next_spanCount = spanCount;
        next_errCount  = errCount;
        next_qState    = qState;
        if (!qrssOn)
        begin
            // idle: drop lock and counts
            next_spanCount = 7'h00;
            next_errCount  = 3'h0;
            next_qState    = rpd_pkg::RPD_HUNT;
        end
        else if (rxBitStrobe)
        begin
            next_refShift  = {refShift[18:0], rxBit};
            next_spanCount = spanCount + 7'h01;
            next_errCount  = errTally;
            if (spanCount == rpd_pkg::QRSS_SPAN_LAST)
            begin
                next_errCount = 3'h0;
                case (qState)
                    rpd_pkg::RPD_HUNT:
                        if (errTally < rpd_pkg::QRSS_ACQ_ERRS)
                            next_qState = rpd_pkg::RPD_LOCK;  // [R6]
                    rpd_pkg::RPD_LOCK:
                        if (errTally >= rpd_pkg::QRSS_LOSS_ERRS)
                            next_qState = rpd_pkg::RPD_HUNT;  // [R6]
                    default:
                        next_qState = rpd_pkg::RPD_HUNT;
                endcase
            end
        end
    end

    // ******************************************
    // output selection and data paths
    // ******************************************
    always_comb
    begin
        // alarm unless pseudo-random mode is active
        if (!qrssOn)
            next_pattern = aisAlarm;                          // [R1]
        else if (qState != rpd_pkg::RPD_LOCK)
            next_pattern = 1'b1;                              // [R5]
        else
            next_pattern = bitErr;                            // [R7]
        // data moves at strobe; clock makes its valid edge later
        next_rxHold = rxBitStrobe ? rxLineBits : rxHold;
        next_rxClk  = (~rxBitStrobe) ^ edgeSel;               // [R8] [R9]
        // serial bit launched on edge opposite to valid edge
        next_serial = serialReadData;
        if (edgeSel && !sclk && sclkPrev)
            next_serial = serialNextBit;                      // [R10]
        else if (!edgeSel && sclk && !sclkPrev)
            next_serial = serialNextBit;                      // [R11]
    end

    // register everything
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            winCount         <= 11'h000;
            zeroCount        <= 3'h0;
            aisAlarm         <= rpd_pkg::RST_ALARM;
            refShift         <= 20'h00000;
            spanCount        <= 7'h00;
            errCount         <= 3'h0;
            qState           <= rpd_pkg::RPD_HUNT;
            patternDetectOut <= rpd_pkg::RST_PATTERN;
            rxHold           <= '0;
            rxClkOut         <= 1'b0;
            sclkPrev         <= 1'b0;
            serialReadData   <= 1'b0;
        end
        else
        begin
            winCount         <= next_winCount;
            zeroCount        <= next_zeroCount;
            aisAlarm         <= next_aisAlarm;
            refShift         <= next_refShift;
            spanCount        <= next_spanCount;
            errCount         <= next_errCount;
            qState           <= next_qState;
            patternDetectOut <= next_pattern;
            rxHold           <= next_rxHold;
            rxClkOut         <= next_rxClk;
            sclkPrev         <= sclk;
            serialReadData   <= next_serial;
        end
    end

    assign rxPositiveData = rxHold.pos;
    assign rxNegativeData = rxHold.neg;

    // ******************************************
    // checks
    // ******************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_winEnd;
        rxBitStrobe && winCount == rpd_pkg::AIS_WIN_LAST;
    endsequence
    sequence s_lockErr;
        qrssOn && qState == rpd_pkg::RPD_LOCK && bitErr;
    endsequence
    sequence s_launchLow;
        rxBitStrobe && !edgeSel ##1 !rxBitStrobe && !edgeSel;
    endsequence
    sequence s_launchHigh;
        rxBitStrobe && edgeSel ##1 !rxBitStrobe && edgeSel;
    endsequence

    chk_ais_mode_route: assert property ( // [R1]
        !qrssOn |=> patternDetectOut == $past(aisAlarm))
        else $error("alarm not routed to detect output");
    chk_ais_alarm_set: assert property ( // [R2]
        s_winEnd and (zeroTally < rpd_pkg::AIS_ZERO_LIMIT) |=> aisAlarm)
        else $error("alarm not raised on few zeros");
    chk_ais_alarm_clear: assert property ( // [R3]
        s_winEnd and (zeroTally > rpd_pkg::AIS_ZERO_LIMIT) |=> !aisAlarm)
        else $error("alarm not cleared on many zeros");
    chk_ais_zero_count: assert property ( // [R4]
        rxBitStrobe && !rxBit && winCount != rpd_pkg::AIS_WIN_LAST &&
        zeroCount < rpd_pkg::AIS_ZERO_SAT
        |=> zeroCount == $past(zeroCount) + 3'h1)
        else $error("line zero not counted");
    chk_ais_window_wrap: assert property ( // [R13]
        s_winEnd |=> winCount == 11'h000 && zeroCount == 3'h0)
        else $error("alarm window did not restart");
    chk_qrss_hunt_high: assert property ( // [R5]
        qrssOn && qState == rpd_pkg::RPD_HUNT |=> patternDetectOut)
        else $error("detect output low before lock");
    chk_qrss_acquire: assert property ( // [R6]
        qrssOn && rxBitStrobe && spanCount == rpd_pkg::QRSS_SPAN_LAST &&
        qState == rpd_pkg::RPD_HUNT && errTally < rpd_pkg::QRSS_ACQ_ERRS
        |=> qState == rpd_pkg::RPD_LOCK)
        else $error("lock not acquired");
    chk_qrss_loss: assert property ( // [R6]
        qrssOn && rxBitStrobe && spanCount == rpd_pkg::QRSS_SPAN_LAST &&
        qState == rpd_pkg::RPD_LOCK && errTally >= rpd_pkg::QRSS_LOSS_ERRS
        |=> qState == rpd_pkg::RPD_HUNT)
        else $error("lock not dropped");
    chk_qrss_err_pulse: assert property ( // [R7]
        s_lockErr |=> patternDetectOut)
        else $error("bit error not pulsed");
    chk_qrss_lock_quiet: assert property ( // [R7]
        qrssOn && qState == rpd_pkg::RPD_LOCK && !bitErr
        |=> !patternDetectOut)
        else $error("detect output high while locked");
    chk_rx_edge_fall: assert property ( // [R8]
        s_launchHigh |=> $fell(rxClkOut) && $stable(rxHold))
        else $error("receive data not valid at falling edge");
    chk_rx_edge_rise: assert property ( // [R9]
        s_launchLow |=> $rose(rxClkOut) && $stable(rxHold))
        else $error("receive data not valid at rising edge");
    chk_sdo_launch_fall: assert property ( // [R10]
        edgeSel && !sclk && sclkPrev
        |=> serialReadData == $past(serialNextBit))
        else $error("serial bit not launched on falling shift");
    chk_sdo_launch_rise: assert property ( // [R11]
        !edgeSel && sclk && !sclkPrev
        |=> serialReadData == $past(serialNextBit))
        else $error("serial bit not launched on rising shift");

endmodule : rpd_monitor

`default_nettype wire

/* File: verification/rpd_framer_model.sv */
// framer capture and external error counter facing the monitor
`default_nettype none

module rpd_framer_model
(
    input  wire logic        rxClkOut,         // receive clock from block
    input  wire logic        rxPositiveData,   // receive data
    input  wire logic        rxNegativeData,   // receive data
    input  wire logic        edgeSelect,       // edge chosen by the pin
    input  wire logic        patternDetectOut, // detect output
    output var  logic        capPos,           // captured positive mark
    output var  logic        capNeg,           // captured negative mark
    output var  logic [15:0] pulseCount        // tallied error pulses
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************
    // framer capture
    // ************************************
    // rising edge capture with edge select low, falling edge with it high
    initial
    begin
        capPos = 1'b0;
        capNeg = 1'b0;
        forever
        begin
            @(rxClkOut);
            if (rxClkOut !== edgeSelect)
            begin
                capPos <= rxPositiveData;
                capNeg <= rxNegativeData;
            end
        end
    end

    // ************************************
    // error counter
    // ************************************
    // each rising pulse on the detect output counts once
    initial
    begin
        pulseCount = 16'h0000;
        forever
        begin
            @(posedge patternDetectOut);
            pulseCount <= pulseCount + 16'h0001;
        end
    end
endmodule : rpd_framer_model

`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the receive pattern monitor
`default_nettype none

`define CHECK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************
    // signals
    // ************************************
    logic                  mclk, rst, rxBitStrobe, edgeSelect;
    logic                  auxFunctionSelect, auxFunctionPin;
    logic                  serialShiftClk, serialNextBit;
    rpd_pkg::rpd_rx_bits_t rxLineBits;    // bit toward the block
    logic                  rxPositiveData, rxNegativeData, rxClkOut;
    logic                  serialReadData, patternDetectOut;
    logic                  capPos, capNeg; // framer captures
    logic [15:0]           pulseCount;     // counter tally
    logic [15:0]           base;           // tally snapshot
    logic [19:0]           lfsr;           // pattern source
    int                    err_count, checked;
    int                    rowZeros [6] = '{0, 5, 3, 2, 3, 4};
    logic                  rowAlarm [6] = '{1'h1, 1'h0, 1'h0,
                                            1'h1, 1'h1, 1'h0};
    logic [3:0]            serRows [8] = '{4'hE, 4'hB, 4'h9, 4'hD,
                                           4'h8, 4'h7, 4'h1, 4'h4};

    rpd_monitor rpd_monitor_i (.mclk(mclk), .rst(rst),
        .rxBitStrobe(rxBitStrobe), .rxLineBits(rxLineBits),
        .edgeSelect(edgeSelect), .auxFunctionSelect(auxFunctionSelect),
        .auxFunctionPin(auxFunctionPin), .serialShiftClk(serialShiftClk),
        .serialNextBit(serialNextBit), .rxPositiveData(rxPositiveData),
        .rxNegativeData(rxNegativeData), .rxClkOut(rxClkOut),
        .serialReadData(serialReadData),
        .patternDetectOut(patternDetectOut));

    rpd_framer_model rpd_framer_model_i (.rxClkOut(rxClkOut),
        .rxPositiveData(rxPositiveData), .rxNegativeData(rxNegativeData),
        .edgeSelect(edgeSelect), .patternDetectOut(patternDetectOut),
        .capPos(capPos), .capNeg(capNeg), .pulseCount(pulseCount));

    // ************************************
    // clock and tasks
    // ************************************
    // 25 MHz clock
    always #20 mclk = ~mclk;

    // one received bit, strobes two cycles apart
    task sendBit(input logic p, input logic n);
        @(posedge mclk);
        rxBitStrobe <= 1'b1;
        rxLineBits  <= '{p, n};
        @(posedge mclk);
        rxBitStrobe <= 1'b0;
    endtask : sendBit

    // pseudo-random bits, one flipped at index flipAt
    task sendPrbs(input int nBits, input int flipAt);
        logic b;
        for (int i = 0; i < nBits; i++)
        begin
            b = lfsr[16] ^ lfsr[19];
            lfsr = {lfsr[18:0], b};
            sendBit(b ^ (i == flipAt), 1'b0);
        end
    endtask : sendPrbs

    // verdict and end of run
    task conclude;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // watchdog well above the expected run
    initial
    begin
        repeat (60000) @(posedge mclk);
        err_count++;
        conclude();
    end

    // ************************************
    // main sequence
    // ************************************
    initial
    begin
        mclk = 0; rst = 1; rxBitStrobe = 0; rxLineBits = '{0, 0};
        edgeSelect = 0; auxFunctionSelect = 0; auxFunctionPin = 0;
        serialShiftClk = 0; serialNextBit = 0; lfsr = 20'h00001;
        err_count = 0; checked = 0;
        @(posedge mclk);
        #1 `CHECK({patternDetectOut, rxClkOut, serialReadData}, 3'h0)
        @(posedge mclk);
        rst <= 1'b0;
        // alarm windows: zero count against alarm level
        foreach (rowZeros[r])
        begin
            for (int i = 0; i < 2048; i++)
                if (i < rowZeros[r]) sendBit(1'b0, 1'b0);
                else sendBit(i[0], !i[0]);
            repeat (2) @(posedge mclk);
            `CHECK(patternDetectOut, rowAlarm[r])
        end
        // serial output: rows of edge, shift clock, bit, expected
        foreach (serRows[r])
        begin
            @(posedge mclk);
            {edgeSelect, serialShiftClk, serialNextBit} <= serRows[r][3:1];
            repeat (6) @(posedge mclk);
            `CHECK(serialReadData, serRows[r][0])
        end
        // receive data capture on the selected edge
        for (int e = 0; e < 2; e++)
        begin
            edgeSelect <= e[0];
            repeat (4) @(posedge mclk);
            for (int k = 1; k < 4; k++)
            begin
                sendBit(k[1], k[0]);
                repeat (2) @(posedge mclk);
                `CHECK({capPos, capNeg}, {k[1], k[0]})
            end
        end
        // pseudo-random: hunt, lock, error pulses, loss
        auxFunctionSelect <= 1'b1;
        auxFunctionPin    <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHECK(patternDetectOut, 1'b1)
        sendPrbs(384, -1);
        repeat (3) @(posedge mclk);
        `CHECK(patternDetectOut, 1'b0)
        base = pulseCount;
        sendPrbs(60, 30);
        repeat (3) @(posedge mclk);
        `CHECK(pulseCount - base, 16'h0003)
        `CHECK(patternDetectOut, 1'b0)
        repeat (256) sendBit(1'b1, 1'b0);
        repeat (3) @(posedge mclk);
        `CHECK(patternDetectOut, 1'b1)
        conclude();
    end
endmodule : tb

`default_nettype wire
